// ===== rtl/rsi_debounce.sv
// push control debouncer producing one pulse per settled press
`timescale 1ns/1ps
module rsi_debounce #(
    parameter int DEB_CYC = rsi_pkg::DEBOUNCE_CYC
) (
    input  wire logic clk_in,      // system clock
    input  wire logic arst_n_in,   // async reset, active low
    input  wire logic raw_in,      // raw push level, high pressed
    output logic      press_out    // one-cycle pulse per press
);
    import rsi_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic             stable_r;
    logic             press_r;

    // bounce resets the count, so only a held level is accepted
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_r    <= '0;
            stable_r <= 1'b0;
        end else if (raw_in == stable_r) begin
            cnt_r <= '0;
        end else if (cnt_r == CNT_W'(DEB_CYC - 1)) begin
            cnt_r    <= '0;
            stable_r <= raw_in;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            press_r <= 1'b0;
        end else begin
            press_r <= (raw_in != stable_r) && raw_in && (cnt_r == CNT_W'(DEB_CYC - 1));
        end
    end

    assign press_out = press_r;

    a_press_single: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        press_r |=> !press_r)
        else $error("press pulse longer than one cycle");

    a_press_held: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        press_r |-> stable_r && $past(raw_in))
        else $error("press without a held input");

endmodule

// ===== rtl/rsi_pkg.sv
// shared constants and types for the router status and mode-select block
package rsi_pkg;

    // clock and timing
    localparam int CLK_KHZ        = 50_000;
    localparam int BLINK_HALF_MS  = 250;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
    localparam int DEBOUNCE_MS    = 10;
    localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * CLK_KHZ;
    localparam int CNT_W          = 24;

    // register byte offsets
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] ROUTE_OFS  = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;

    // field positions
    localparam int CTRL_FRAME_EN_BIT = 0;
    localparam int CTRL_MANUAL_BIT   = 1;
    localparam int ROUTE_SWAP_BIT    = 0;
    localparam int STAT_ROUTE_BIT    = 11;
    localparam int STAT_MONITOR_BIT  = 12;
    localparam int STAT_REMOTE_BIT   = 13;
    localparam int STAT_DIP_LSB      = 16;
    localparam int DIP_REMOTE_BIT    = 0;
    localparam int DIP_MONITOR_BIT   = 7;

    // display codes
    localparam logic [3:0] ROUTE_DIRECT_CODE  = 4'h1;
    localparam logic [3:0] ROUTE_SWAPPED_CODE = 4'h2;

    typedef struct packed {
        logic       manual;
        logic       frame_en;
    } rsi_cfg_type;

    localparam rsi_cfg_type CFG_RST = 2'h1;

    typedef struct packed {
        logic       vid_a;
        logic       vid_b;
        logic       power_good;
        logic       power_fault;
        logic       genlock;
        logic [3:0] grp_a;
        logic [3:0] grp_b;
    } rsi_detect_type;

    typedef struct packed {
        logic       fault;
        logic       health;
        logic       pres_a;
        logic       pres_b;
        logic       prog_a;
        logic       prog_b;
        logic       ref_pres;
        logic [3:0] audio;
    } rsi_lamps_type;

    typedef enum logic {ROUTE_DIRECT, ROUTE_SWAPPED} rsi_route_type;

endpackage

// ===== rtl/rsi_top.sv
// router card status lamps, mode switches, display select and register slave
// Operation
// - fault lamp on when input missing or power fault
// - fault copied to frame status when enabled
// - health lamp needs both inputs and power
// - first presence lamp follows input one
// - second presence lamp follows input two
// - first routing lamp when input one programs
// - second routing lamp when input two programs
// - reference lamp follows genlock detection
// - audio lamp one from input one groups
// - audio lamp two from input one groups
// - audio lamp three from input two groups
// - audio lamp four from input two groups
// - switch one off: local config only
// - switch one on: remote network config
// - switch eight off: display runs menu
// - switch eight on: display shows routing
// - monitor manual press changes routing
// - distinct codes for direct and swapped routing
`timescale 1ns/1ps
module rsi_top #(
    parameter int BLINK_HALF = rsi_pkg::BLINK_HALF_CYC,
    parameter int DEB_CYC    = rsi_pkg::DEBOUNCE_CYC
) (
    input  wire logic                   clk_in,              // system clock
    input  wire logic                   arst_n_in,           // async reset, active low
    input  wire rsi_pkg::rsi_detect_type detect_in,          // detector levels
    input  wire logic [7:0]             dip_sw_in,           // config switches, high on
    input  wire logic                   push_btn_in,         // push control, high pressed
    input  wire logic                   toggle_up_in,        // toggle lifted
    input  wire logic                   toggle_dn_in,        // toggle pushed down
    input  wire logic                   local_cfg_we_in,     // local menu config strobe
    input  wire rsi_pkg::rsi_cfg_type   local_cfg_in,        // local menu config value
    input  wire logic [3:0]             avs_address_in,      // byte address
    input  wire logic                   avs_read_in,         // read request
    input  wire logic                   avs_write_in,        // write request
    input  wire logic [31:0]            avs_writedata_in,    // write data
    output logic [31:0]                 avs_readdata_out,    // read data
    output logic                        avs_waitrequest_out, // stall
    output rsi_pkg::rsi_lamps_type      lamps_out,           // eleven card lamps
    output logic                        frame_fault_out,     // fault to frame status
    output logic                        remote_en_out,       // network control active
    output logic                        disp_monitor_out,    // display shows routing
    output logic [3:0]                  disp_code_out,       // routing code shown
    output logic                        menu_push_out,       // press to menu engine
    output logic                        menu_up_out,         // toggle up to menu engine
    output logic                        menu_dn_out,         // toggle down to menu engine
    output logic                        route_swapped_out    // input two on program
);
    import rsi_pkg::*;

    logic             ack_r;
    logic [31:0]      readdata_r;
    logic [31:0]      rd_mux;
    logic             bus_wr;
    rsi_cfg_type      cfg_r;
    rsi_route_type    route_r;
    rsi_lamps_type    lamps_r;
    logic             frame_fault_r;
    logic [CNT_W-1:0] blink_cnt_r;
    logic             blink_r;
    logic             press;
    logic             remote;
    logic             monitor;
    logic             disp_monitor_r;
    logic [3:0]       disp_code_r;
    logic [2:0]       menu_r;

    function automatic logic audio_lamp(input logic [1:0] grp, input logic blink);
        logic lamp;
        lamp = 1'b0;
        case (grp)
            2'h3:    lamp = 1'b1;
            2'h1:    lamp = blink;
            2'h2:    lamp = blink;
            default: lamp = 1'b0;
        endcase
        return lamp;
    endfunction

    assign remote  = dip_sw_in[DIP_REMOTE_BIT];
    assign monitor = dip_sw_in[DIP_MONITOR_BIT];

    rsi_debounce #(
        .DEB_CYC   (DEB_CYC)
    ) rsi_debounce_inst (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .raw_in    (push_btn_in),
        .press_out (press)
    );

    // one wait state keeps read data off a combinational path
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
    assign bus_wr              = avs_write_in & ack_r;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
        end
    end

    always_comb begin
        rd_mux = '0;
        case (avs_address_in)
            CTRL_OFS:   rd_mux = 32'(cfg_r);
            ROUTE_OFS:  rd_mux = 32'(route_r == ROUTE_SWAPPED);
            STATUS_OFS: begin
                rd_mux[10:0]                = lamps_r;
                rd_mux[STAT_ROUTE_BIT]      = (route_r == ROUTE_SWAPPED);
                rd_mux[STAT_MONITOR_BIT]    = monitor;
                rd_mux[STAT_REMOTE_BIT]     = remote;
                rd_mux[STAT_DIP_LSB +: 8]   = dip_sw_in;
            end
            default:    rd_mux = '0;
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            readdata_r <= '0;
        end else if (avs_read_in && !ack_r) begin
            readdata_r <= rd_mux;
        end
    end

    assign avs_readdata_out = readdata_r;

    // configuration source chosen by switch one
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cfg_r <= CFG_RST;
        end else if (remote) begin
            if (bus_wr && avs_address_in == CTRL_OFS) begin
                cfg_r.frame_en <= avs_writedata_in[CTRL_FRAME_EN_BIT];
                cfg_r.manual   <= avs_writedata_in[CTRL_MANUAL_BIT];
            end
        end else if (local_cfg_we_in) begin
            cfg_r <= local_cfg_in;
        end
    end

    // routing state; press wins over a remote write in the same cycle
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            route_r <= ROUTE_DIRECT;
        end else if (press && monitor && cfg_r.manual) begin
            case (route_r)
                ROUTE_DIRECT:  route_r <= ROUTE_SWAPPED;
                ROUTE_SWAPPED: route_r <= ROUTE_DIRECT;
                default:       route_r <= ROUTE_DIRECT;
            endcase
        end else if (remote && bus_wr && avs_address_in == ROUTE_OFS) begin
            route_r <= avs_writedata_in[ROUTE_SWAP_BIT] ? ROUTE_SWAPPED : ROUTE_DIRECT;
        end
    end

    assign route_swapped_out = (route_r == ROUTE_SWAPPED);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            blink_cnt_r <= '0;
            blink_r     <= 1'b0;
        end else if (blink_cnt_r == CNT_W'(BLINK_HALF - 1)) begin
            blink_cnt_r <= '0;
            blink_r     <= ~blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            lamps_r <= '0;
        end else begin
            lamps_r.fault    <= ~(detect_in.vid_a & detect_in.vid_b) | detect_in.power_fault;
            lamps_r.health   <= detect_in.vid_a & detect_in.vid_b & detect_in.power_good;
            lamps_r.pres_a   <= detect_in.vid_a;
            lamps_r.pres_b   <= detect_in.vid_b;
            lamps_r.prog_a   <= (route_r == ROUTE_DIRECT);
            lamps_r.prog_b   <= (route_r == ROUTE_SWAPPED);
            lamps_r.ref_pres <= detect_in.genlock;
            lamps_r.audio[0] <= audio_lamp(detect_in.grp_a[1:0], blink_r);
            lamps_r.audio[1] <= audio_lamp(detect_in.grp_a[3:2], blink_r);
            lamps_r.audio[2] <= audio_lamp(detect_in.grp_b[1:0], blink_r);
            lamps_r.audio[3] <= audio_lamp(detect_in.grp_b[3:2], blink_r);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            frame_fault_r <= 1'b0;
        end else begin
            frame_fault_r <= (~(detect_in.vid_a & detect_in.vid_b) | detect_in.power_fault)
                             & cfg_r.frame_en;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            disp_monitor_r <= 1'b0;
            disp_code_r    <= '0;
            menu_r         <= '0;
        end else begin
            disp_monitor_r <= monitor;
            disp_code_r    <= !monitor ? 4'h0 :
                              (route_r == ROUTE_SWAPPED) ? ROUTE_SWAPPED_CODE
                                                         : ROUTE_DIRECT_CODE;
            menu_r         <= monitor ? 3'h0 : {press, toggle_up_in, toggle_dn_in};
        end
    end

    assign lamps_out        = lamps_r;
    assign frame_fault_out  = frame_fault_r;
    assign remote_en_out    = remote;
    assign disp_monitor_out = disp_monitor_r;
    assign disp_code_out    = disp_code_r;
    assign menu_push_out    = menu_r[2];
    assign menu_up_out      = menu_r[1];
    assign menu_dn_out      = menu_r[0];

    a_fault_lamp: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        1'b1 |=> lamps_r.fault == (!($past(detect_in.vid_a) && $past(detect_in.vid_b))
                                   || $past(detect_in.power_fault)))
        else $error("fault lamp does not follow inputs");

    a_frame_report: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        1'b1 |=> frame_fault_out == (lamps_r.fault && $past(cfg_r.frame_en)))
        else $error("frame status disagrees with fault lamp");

    // fault and health may both be lit when power fault and power good coexist
    a_health_lamp: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        1'b1 |=> lamps_r.health == ($past(detect_in.vid_a) && $past(detect_in.vid_b)
                                    && $past(detect_in.power_good)))
        else $error("health lamp disagrees with inputs");

    a_presence_lamps: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        1'b1 |=> lamps_r.pres_a == $past(detect_in.vid_a)
                 && lamps_r.pres_b == $past(detect_in.vid_b))
        else $error("presence lamp wrong");

    a_route_lamps: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        1'b1 |=> lamps_r.prog_b == $past(route_swapped_out)
                 && lamps_r.prog_a == !$past(route_swapped_out))
        else $error("routing lamps wrong");

    a_ref_lamp: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $rose(detect_in.genlock) |=> lamps_r.ref_pres)
        else $error("reference lamp missed");

    a_audio_flash: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (detect_in.grp_a[1:0] == 2'h1) [*2] |=> lamps_r.audio[0] == $past(blink_r))
        else $error("audio lamp not flashing on one group");

    a_audio_steady: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        detect_in.grp_b[1:0] == 2'h3 |=> lamps_r.audio[2])
        else $error("audio lamp three not steady with both groups");

    a_audio_steady_four: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        detect_in.grp_b[3:2] == 2'h3 |=> lamps_r.audio[3])
        else $error("audio lamp four not steady with both groups");

    a_remote_ignored: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !remote && bus_wr && !local_cfg_we_in |=> $stable(cfg_r))
        else $error("remote write accepted in local mode");

    a_remote_cfg: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        remote && bus_wr && avs_address_in == CTRL_OFS
        |=> cfg_r == $past(avs_writedata_in[1:0]))
        else $error("remote config write lost");

    // code is launched from the route of the previous cycle
    a_display_code: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        monitor |=> disp_code_out == ($past(route_swapped_out) ? ROUTE_SWAPPED_CODE
                                                                : ROUTE_DIRECT_CODE))
        else $error("wrong routing code shown");

    a_menu_gated: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        monitor |=> !menu_push_out && !menu_up_out && !menu_dn_out)
        else $error("menu keys leaked in monitor mode");

    a_press_swap: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        press && monitor && cfg_r.manual |=> route_r != $past(route_r))
        else $error("press did not swap routing");

    a_blink_edge: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $changed(blink_r) |-> blink_cnt_r == '0 && $past(blink_cnt_r) != '0)
        else $error("blink toggled off the divider wrap");

    c_press_swap: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        press && monitor && cfg_r.manual ##1 route_r == ROUTE_SWAPPED);
    c_remote_cfg: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        remote && bus_wr && avs_address_in == CTRL_OFS);
    c_status_read: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        avs_read_in && ack_r && avs_address_in == STATUS_OFS);
    c_audio_flash: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        detect_in.grp_a[1:0] == 2'h2 ##1 lamps_r.audio[0] ##1 !lamps_r.audio[0]);

endmodule

// ===== tb/rsi_panel_model.sv
// partner model: card edge switch bank and a bouncing push control
`timescale 1ns/1ps
module rsi_panel_model (
    input  wire logic       clk_in,        // system clock
    input  wire logic       sw_remote_in,  // switch 1 wanted on
    input  wire logic       sw_monitor_in, // switch 8 wanted on
    input  wire logic       press_req_in,  // one-cycle request for a press
    output logic [7:0]      dip_sw_out,    // switch bank, bit0 = switch 1
    output logic            push_btn_out   // push level, high pressed
);
    logic [5:0] step_r = 6'h00;
    assign dip_sw_out = {sw_monitor_in, 6'h00, sw_remote_in};
    // a one-cycle blip first, so an undebounced design would count twice
    assign push_btn_out = (step_r == 6'h01) || (step_r > 6'h02 && step_r < 6'h10);
    // sequence ends at step 16 so a following press request is not swallowed
    always_ff @(posedge clk_in) begin
        if (step_r == 6'h10) begin
            step_r <= 6'h00;
        end else if (step_r != 6'h00 || press_req_in) begin
            step_r <= step_r + 6'h01;
        end
    end
endmodule

// ===== tb/tb_router_status_indicators.sv
// self-checking bench for the router status and mode-select block
`timescale 1ns/1ps
module tb_router_status_indicators;
    import rsi_pkg::*;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    rsi_detect_type det = '0;
    rsi_cfg_type lcfg = '0;
    rsi_lamps_type lamps;
    logic sw1 = 1'b0, sw8 = 1'b0, preq = 1'b0, tup = 1'b0, tdn = 1'b0, lwe = 1'b0;
    logic av_rd = 1'b0, av_wr = 1'b0, wreq, push, ffault, remote, mon, mpush, mup, mdn, swp;
    logic [3:0] av_addr = 4'h0, code;
    logic [7:0] dip;
    logic [31:0] av_wd = 32'h0, rdata, q;
    int n_fail = 0;
    int num_checks = 0;

    always #10 clk_in = ~clk_in;

    rsi_panel_model rsi_panel_model_inst (.clk_in(clk_in), .sw_remote_in(sw1),
        .sw_monitor_in(sw8), .press_req_in(preq), .dip_sw_out(dip), .push_btn_out(push));
    rsi_top #(.BLINK_HALF(8), .DEB_CYC(4)) rsi_top_inst (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .detect_in(det), .dip_sw_in(dip), .push_btn_in(push),
        .toggle_up_in(tup), .toggle_dn_in(tdn), .local_cfg_we_in(lwe), .local_cfg_in(lcfg),
        .avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
        .avs_writedata_in(av_wd), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .lamps_out(lamps), .frame_fault_out(ffault), .remote_en_out(remote),
        .disp_monitor_out(mon), .disp_code_out(code), .menu_push_out(mpush),
        .menu_up_out(mup), .menu_dn_out(mdn), .route_swapped_out(swp));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // one transfer; the request holds until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        logic busy;
        int   n;
        @(posedge clk_in);
        av_wr <= w;
        av_rd <= !w;
        av_addr <= a;
        av_wd <= d;
        busy = 1'b1;
        n = 0;
        while (busy && n < 50) begin
            @(posedge clk_in);
            busy = (wreq !== 1'b0);
            q = rdata;
            n++;
        end
        if (busy) n_fail++;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask

    // press through the partner; returns how often the route and menu pulse moved
    task automatic press(output int flips, output int pulses);
        logic last;
        preq <= 1'b1;
        tick(1);
        preq <= 1'b0;
        flips = 0;
        pulses = 0;
        last = swp;
        repeat (60) begin
            @(negedge clk_in);
            flips += (swp !== last);
            pulses += (mpush === 1'b1);
            last = swp;
        end
        tick(1);
    endtask

    task automatic t_health();
        logic f;
        for (int i = 0; i < 16; i++) begin
            {det.vid_a, det.vid_b, det.power_good, det.power_fault} <= i[3:0];
            det.genlock <= i[0];
            tick(3);
            f = !(i[3] && i[2]) || i[0];
            chk({ffault, lamps.fault, lamps.health, lamps.pres_a, lamps.pres_b, lamps.ref_pres},
                {f, f, i[3] & i[2] & i[1], i[3], i[2], i[0]});
        end
    endtask

    task automatic t_audio();
        logic [7:0] g;
        int hi, chg, cls;
        logic last, others;
        for (int k = 0; k < 4; k++) begin
            for (int p = 0; p < 4; p++) begin
                g = 8'h00;
                g[2*k +: 2] = p[1:0];
                det.grp_a <= g[3:0];
                det.grp_b <= g[7:4];
                tick(3);
                hi = 0;
                chg = 0;
                others = 1'b0;
                last = lamps.audio[k];
                repeat (40) begin
                    @(negedge clk_in);
                    hi += (lamps.audio[k] === 1'b1);
                    chg += (lamps.audio[k] !== last);
                    last = lamps.audio[k];
                    others |= |(lamps.audio & ~(4'h1 << k));
                end
                cls = others ? 7 : (hi == 0) ? 0 : (hi == 40) ? 3 : (chg >= 4 && chg <= 5) ? 1 : 2;
                chk(cls, (p == 3) ? 3 : (p == 0) ? 0 : 1);
                tick(1);
            end
        end
    endtask

    task automatic t_remote();
        bus(1'b0, CTRL_OFS, 32'h0);
        chk(q, 32'h1);
        det.vid_a <= 1'b0;
        bus(1'b1, ROUTE_OFS, 32'h1);
        bus(1'b0, ROUTE_OFS, 32'h0);
        chk({q[0], swp, remote}, 3'b000);
        lcfg <= 2'h0;
        lwe <= 1'b1;
        tick(1);
        lwe <= 1'b0;
        tick(3);
        chk({lamps.fault, ffault}, 2'b10);
        sw1 <= 1'b1;
        lcfg <= 2'h1;
        lwe <= 1'b1;
        tick(1);
        lwe <= 1'b0;
        tick(3);
        chk({remote, ffault}, 2'b10);
        bus(1'b1, CTRL_OFS, 32'h1);
        bus(1'b1, ROUTE_OFS, 32'h1);
        tick(3);
        chk({ffault, swp, lamps.prog_a, lamps.prog_b}, 4'b1101);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk({q[23:16], q[13], q[11]}, {8'h01, 1'b1, 1'b1});
        bus(1'b1, ROUTE_OFS, 32'h0);
        tick(3);
        chk({swp, lamps.prog_a, lamps.prog_b}, 3'b010);
        bus(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        det.vid_a <= 1'b1;
    endtask

    task automatic t_display();
        int fl, pu;
        tup <= 1'b1;
        tick(3);
        chk({mon, code, mup, mdn}, 7'h02);
        tup <= 1'b0;
        tdn <= 1'b1;
        tick(3);
        chk({mup, mdn}, 2'b01);
        press(fl, pu);
        chk({fl[15:0], pu[15:0]}, {16'd0, 16'd1});
        sw8 <= 1'b1;
        bus(1'b1, CTRL_OFS, 32'h3);
        tick(3);
        chk({mon, code, mup, mdn}, {1'b1, ROUTE_DIRECT_CODE, 2'b00});
        press(fl, pu);
        chk({fl[15:0], pu[15:0]}, {16'd1, 16'd0});
        chk({code, lamps.prog_b}, {ROUTE_SWAPPED_CODE, 1'b1});
        press(fl, pu);
        chk({fl[7:0], code, swp}, {8'd1, ROUTE_DIRECT_CODE, 1'b0});
        bus(1'b1, CTRL_OFS, 32'h1);
        press(fl, pu);
        chk(fl, 32'd0);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_fail++;
        wrap_up();
    end

    initial begin
        tick(5);
        arst_n_in <= 1'b1;
        t_health();
        t_audio();
        t_remote();
        t_display();
        wrap_up();
    end
endmodule
